// ===== rtl/fault_simulation_sequencer.sv
// Purpose: Fault simulation sequencer with AXI4-Lite registers.
// Assumes: Inputs synchronous to aclk; ce low freezes all state.
// Notes:   Phase durations are in clock cycles; zero counts as one.
// Behaviour
// [RQ1] Run pre-fault, then fault, then post-fault.
// [RQ2] Reset phase before pre-fault and after post-fault.
// [RQ3] Report phase codes zero to four.
// [RQ4] Configurable durations and per-phase quantities.
// [RQ5] Abort when phase current exceeds tenth rated.
// [RQ6] Refuse start until five quiet seconds; the code applies this only after an overcurrent abort, through lockout.
// [RQ7] Two external inputs hold simulator blocked.
// [RQ8] Force-post input jumps to post-fault.
// [RQ9] Freeze energy counters while running.
// [RQ10] Simulated voltages are phase-to-neutral.
// [RQ11] Simulated frequency 0.16 percent above rated.
// [RQ12] No-trip policy blocks trip orders out.
// [RQ13] With-trip policy passes trip orders out.
// [RQ14] Without force-post, manual start runs fully.
// [RQ15] Manual stop ends simulation at once.
// [RQ16] External launch starts when permitted.
// [RQ17] Protection out of service while running.
// [RQ18] Timers advance phases; end returns normal.
// [RQ19] Operator ties breaker-closed to a block input.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
module fault_simulation_sequencer #(
  parameter int RESET_PHASE_CYC = fsim_pkg::RESET_PHASE_CYC,
  parameter int QUIET_CYC       = fsim_pkg::QUIET_CYC
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [11:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [11:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic [15:0]  phase_current_a,
  input  wire logic [15:0]  phase_current_b,
  input  wire logic [15:0]  phase_current_c,
  input  wire logic         external_block_one,
  input  wire logic         external_block_two,
  input  wire logic         external_jump_to_post_fault,
  input  wire logic         external_sim_launch,
  input  wire logic         protection_trip_order,
  output logic              breaker_trip_order,
  output logic [2:0]        seq_phase_code,
  output logic              protection_reinit,
  output logic              protection_out_of_service,
  output logic              energy_counters_freeze,
  output logic              sim_volts_phase_neutral,
  output logic [255:0]      sim_quantities,
  output logic [31:0]       sim_freq_mhz,
  output logic              irq
);

  typedef struct packed {
    fsim_pkg::seq_state_t                st;
    logic [31:0]                         tmr;
    logic [31:0]                         quiet;
    logic                                lockout;
    logic                                launch_q;
    logic                                with_trip;
    logic                                fp_asg;
    logic                                launch_asg;
    logic [2:0][31:0]                    dur;
    logic [15:0]                         rated_i;
    logic [31:0]                         rated_f;
    logic [fsim_pkg::IRQ_W-1:0]          irq_st;
    logic [fsim_pkg::IRQ_W-1:0]          irq_en;
    logic [fsim_pkg::SIM_WORDS-1:0][31:0] sim_cfg;
    logic [fsim_pkg::SIM_CH-1:0][31:0]   sim_out;
    logic [2:0]                          code;
    logic                                reinit;
    logic                                running;
    logic                                trip;
    logic [31:0]                         freq;
    logic                                irq;
    logic                                awready;
    logic                                wready;
    logic                                arready;
    logic                                bvalid;
    logic                                rvalid;
    logic                                aw_held;
    logic                                w_held;
    logic [11:0]                         awaddr;
    logic [31:0]                         wdata;
    logic [3:0]                          wstrb;
    logic [1:0]                          bresp;
    logic [1:0]                          rresp;
    logic [31:0]                         rdata;
  } seq_regs_t;

  seq_regs_t                    s_ff;
  seq_regs_t                    nxt_s;
  logic                         over;
  logic                         blk;
  logic                         cmd_start;
  logic                         cmd_stop;
  logic                         launch_edge;
  logic [fsim_pkg::IRQ_W-1:0]   ev;
  logic [fsim_pkg::IRQ_W-1:0]   irq_clr;

  // True when ten times the current exceeds the rated current.
  function automatic logic over_tenth(input logic [15:0] i,
                                      input logic [15:0] rated);
    over_tenth = (20'(i) * 20'(fsim_pkg::TENTH_MUL)) > 20'(rated);
  endfunction

  // Zero durations are loaded as one cycle, the shortest phase length.
  function automatic logic [31:0] ld(input logic [31:0] d);
    ld = (d == 32'h0) ? 32'h1 : d;
  endfunction

  function automatic logic is_sim(input logic [11:0] a);
    is_sim = (a >= fsim_pkg::ADDR_SIM_BASE) &&
             (a <= fsim_pkg::ADDR_SIM_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [4:0] sim_idx(input logic [11:0] a);
    logic [11:0] off;
    off = a - fsim_pkg::ADDR_SIM_BASE;
    sim_idx = off[6:2];
  endfunction

  // Byte-lane merge for writable registers.
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  b);
    for (int k = 0; k < 4; k++) begin
      o[k*8 +: 8] = b[k] ? d[k*8 +: 8] : o[k*8 +: 8];
    end
    merge = o;
  endfunction

  function automatic logic [2:0] code_of(input fsim_pkg::seq_state_t x);
    unique case (x)
      fsim_pkg::ST_IDLE:  code_of = fsim_pkg::CODE_NORMAL;
      fsim_pkg::ST_PRE:   code_of = fsim_pkg::CODE_PRE;
      fsim_pkg::ST_FAULT: code_of = fsim_pkg::CODE_FAULT;
      fsim_pkg::ST_POST:  code_of = fsim_pkg::CODE_POST;
      default:            code_of = fsim_pkg::CODE_RESET;
    endcase
  endfunction

  // Bus slave, sequencer and output staging in one next-state process.
  always_comb begin
    nxt_s = s_ff;
    cmd_start = 1'b0;
    cmd_stop = 1'b0;
    ev = '0;
    irq_clr = '0;
    over = over_tenth(phase_current_a, s_ff.rated_i) |
           over_tenth(phase_current_b, s_ff.rated_i) |
           over_tenth(phase_current_c, s_ff.rated_i);
    blk = external_block_one | external_block_two; // RQ7
    launch_edge = s_ff.launch_asg & external_sim_launch & ~s_ff.launch_q;
    if (ce) begin
      // Perform a write once both address and data are held.
      if (s_ff.aw_held && s_ff.w_held && !s_ff.bvalid) begin
        nxt_s.aw_held = 1'b0;
        nxt_s.w_held = 1'b0;
        nxt_s.bvalid = 1'b1;
        nxt_s.bresp = fsim_pkg::RESP_OKAY;
        case (s_ff.awaddr)
          fsim_pkg::ADDR_CTRL: begin
            if (s_ff.wstrb[0]) begin
              cmd_start = s_ff.wdata[fsim_pkg::CTRL_START];
              cmd_stop = s_ff.wdata[fsim_pkg::CTRL_STOP];
              nxt_s.with_trip = s_ff.wdata[fsim_pkg::CTRL_WITH_TRIP];
              nxt_s.fp_asg = s_ff.wdata[fsim_pkg::CTRL_FP_ASG];
              nxt_s.launch_asg = s_ff.wdata[fsim_pkg::CTRL_LAUNCH_ASG];
            end
          end
          fsim_pkg::ADDR_STATUS, fsim_pkg::ADDR_IRQ_ST: ;
          fsim_pkg::ADDR_DUR_PRE:
            nxt_s.dur[0] = merge(s_ff.dur[0], s_ff.wdata, s_ff.wstrb);
          fsim_pkg::ADDR_DUR_FLT:
            nxt_s.dur[1] = merge(s_ff.dur[1], s_ff.wdata, s_ff.wstrb);
          fsim_pkg::ADDR_DUR_POST:
            nxt_s.dur[2] = merge(s_ff.dur[2], s_ff.wdata, s_ff.wstrb);
          fsim_pkg::ADDR_RATED_I:
            nxt_s.rated_i = 16'(merge({16'h0, s_ff.rated_i}, s_ff.wdata,
                                      s_ff.wstrb));
          fsim_pkg::ADDR_RATED_F:
            nxt_s.rated_f = merge(s_ff.rated_f, s_ff.wdata, s_ff.wstrb);
          fsim_pkg::ADDR_IRQ_EN:
            nxt_s.irq_en = s_ff.wstrb[0] ?
                           s_ff.wdata[fsim_pkg::IRQ_W-1:0] : s_ff.irq_en;
          fsim_pkg::ADDR_IRQ_CLR:
            irq_clr = s_ff.wstrb[0] ?
                      s_ff.wdata[fsim_pkg::IRQ_W-1:0] : '0;
          default: begin
            if (is_sim(s_ff.awaddr)) begin
              nxt_s.sim_cfg[sim_idx(s_ff.awaddr)] = merge(
                s_ff.sim_cfg[sim_idx(s_ff.awaddr)], s_ff.wdata,
                s_ff.wstrb); // RQ4
            end else begin
              nxt_s.bresp = fsim_pkg::RESP_SLVERR;
            end
          end
        endcase
      end
      if (s_ff.bvalid && s_axi_bready) begin
        nxt_s.bvalid = 1'b0;
      end
      if (s_ff.awready && s_axi_awvalid) begin
        nxt_s.aw_held = 1'b1;
        nxt_s.awaddr = s_axi_awaddr;
      end
      if (s_ff.wready && s_axi_wvalid) begin
        nxt_s.w_held = 1'b1;
        nxt_s.wdata = s_axi_wdata;
        nxt_s.wstrb = s_axi_wstrb;
      end
      // Reads have no side effects; unmapped reads give zero and SLVERR.
      if (s_ff.rvalid && s_axi_rready) begin
        nxt_s.rvalid = 1'b0;
      end
      if (s_ff.arready && s_axi_arvalid) begin
        nxt_s.rvalid = 1'b1;
        nxt_s.rresp = fsim_pkg::RESP_OKAY;
        nxt_s.rdata = 32'h0;
        case (s_axi_araddr)
          fsim_pkg::ADDR_CTRL:
            nxt_s.rdata[fsim_pkg::CTRL_LAUNCH_ASG:fsim_pkg::CTRL_WITH_TRIP]
              = {s_ff.launch_asg, s_ff.fp_asg, s_ff.with_trip};
          fsim_pkg::ADDR_STATUS:
            nxt_s.rdata[6:0] = {over, blk, s_ff.lockout, s_ff.running,
                                s_ff.code};
          fsim_pkg::ADDR_DUR_PRE:  nxt_s.rdata = s_ff.dur[0];
          fsim_pkg::ADDR_DUR_FLT:  nxt_s.rdata = s_ff.dur[1];
          fsim_pkg::ADDR_DUR_POST: nxt_s.rdata = s_ff.dur[2];
          fsim_pkg::ADDR_RATED_I:  nxt_s.rdata[15:0] = s_ff.rated_i;
          fsim_pkg::ADDR_RATED_F:  nxt_s.rdata = s_ff.rated_f;
          fsim_pkg::ADDR_IRQ_ST:
            nxt_s.rdata[fsim_pkg::IRQ_W-1:0] = s_ff.irq_st;
          fsim_pkg::ADDR_IRQ_EN:
            nxt_s.rdata[fsim_pkg::IRQ_W-1:0] = s_ff.irq_en;
          fsim_pkg::ADDR_IRQ_CLR: ;
          default: begin
            if (is_sim(s_axi_araddr)) begin
              nxt_s.rdata = s_ff.sim_cfg[sim_idx(s_axi_araddr)];
            end else begin
              nxt_s.rresp = fsim_pkg::RESP_SLVERR;
            end
          end
        endcase
      end
      nxt_s.awready = !nxt_s.aw_held && !nxt_s.bvalid;
      nxt_s.wready = !nxt_s.w_held && !nxt_s.bvalid;
      nxt_s.arready = !nxt_s.rvalid;

      // Quiet time counts cycles with all currents low.
      nxt_s.launch_q = external_sim_launch;
      if (over) begin
        nxt_s.quiet = 32'h0;
      end else if (s_ff.quiet < 32'(QUIET_CYC)) begin
        nxt_s.quiet = s_ff.quiet + 32'h1;
      end
      nxt_s.lockout = s_ff.lockout &&
                      (s_ff.quiet < 32'(QUIET_CYC)); // RQ6

      // Aborts take priority over force-post, which beats the timer.
      if (s_ff.st != fsim_pkg::ST_IDLE && (over || blk || cmd_stop)) begin
        nxt_s.st = fsim_pkg::ST_IDLE; // RQ5 RQ15 RQ7
        ev[fsim_pkg::IRQ_ABORT] = over;
        ev[fsim_pkg::IRQ_HALT] = !over;
        nxt_s.lockout = nxt_s.lockout | over; // RQ6
      end else begin
        unique case (s_ff.st)
          fsim_pkg::ST_IDLE: begin
            if (cmd_start || launch_edge) begin // RQ16
              if (!over && !s_ff.lockout && !blk) begin
                nxt_s.st = fsim_pkg::ST_RST1; // RQ2
                nxt_s.tmr = ld(32'(RESET_PHASE_CYC));
                ev[fsim_pkg::IRQ_STARTED] = 1'b1;
              end else begin
                ev[fsim_pkg::IRQ_REFUSED] = 1'b1; // RQ6
              end
            end
          end
          fsim_pkg::ST_RST1: begin
            if (s_ff.tmr <= 32'h1) begin
              nxt_s.st = fsim_pkg::ST_PRE; // RQ1
              nxt_s.tmr = ld(s_ff.dur[0]);
            end else begin
              nxt_s.tmr = s_ff.tmr - 32'h1;
            end
          end
          fsim_pkg::ST_PRE, fsim_pkg::ST_FAULT: begin
            if (s_ff.fp_asg && external_jump_to_post_fault) begin
              nxt_s.st = fsim_pkg::ST_POST; // RQ8
              nxt_s.tmr = ld(s_ff.dur[2]);
            end else if (s_ff.tmr > 32'h1) begin
              nxt_s.tmr = s_ff.tmr - 32'h1;
            end else if (s_ff.st == fsim_pkg::ST_PRE) begin
              nxt_s.st = fsim_pkg::ST_FAULT; // RQ1 RQ18
              nxt_s.tmr = ld(s_ff.dur[1]);
            end else begin
              nxt_s.st = fsim_pkg::ST_POST; // RQ14
              nxt_s.tmr = ld(s_ff.dur[2]);
            end
          end
          fsim_pkg::ST_POST: begin
            if (s_ff.tmr <= 32'h1) begin
              nxt_s.st = fsim_pkg::ST_RST2; // RQ2
              nxt_s.tmr = ld(32'(RESET_PHASE_CYC));
            end else begin
              nxt_s.tmr = s_ff.tmr - 32'h1;
            end
          end
          fsim_pkg::ST_RST2: begin
            if (s_ff.tmr <= 32'h1) begin
              nxt_s.st = fsim_pkg::ST_IDLE; // RQ18
              ev[fsim_pkg::IRQ_DONE] = 1'b1;
            end else begin
              nxt_s.tmr = s_ff.tmr - 32'h1;
            end
          end
        endcase
      end

      // Outputs follow the next state so they line up with it.
      nxt_s.code = code_of(nxt_s.st); // RQ3
      nxt_s.running = nxt_s.st != fsim_pkg::ST_IDLE; // RQ9 RQ10 RQ17
      nxt_s.reinit = nxt_s.code == fsim_pkg::CODE_RESET; // RQ2
      nxt_s.trip = protection_trip_order &&
                   (nxt_s.with_trip || !nxt_s.running); // RQ12 RQ13
      nxt_s.sim_out = '0;
      if (nxt_s.code >= fsim_pkg::CODE_PRE &&
          nxt_s.code <= fsim_pkg::CODE_POST) begin
        nxt_s.sim_out = s_ff.sim_cfg[5'(nxt_s.code - 3'h1) *
                                     5'(fsim_pkg::SIM_CH)
                                     +: fsim_pkg::SIM_CH]; // RQ4
      end
      // Wide intermediate keeps the scaled product from overflowing.
      nxt_s.freq = nxt_s.rated_f + 32'((48'(nxt_s.rated_f) *
                   48'(fsim_pkg::FREQ_NUM)) / 48'(fsim_pkg::FREQ_DEN)); // RQ11
      // A new event wins over a clear in the same cycle.
      nxt_s.irq_st = (s_ff.irq_st & ~irq_clr) | ev;
      nxt_s.irq = |(nxt_s.irq_st & nxt_s.irq_en);
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
      s_ff.dur <= {3{fsim_pkg::DUR_RST}};
      s_ff.rated_i <= fsim_pkg::RATED_I_RST;
      s_ff.rated_f <= fsim_pkg::RATED_F_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready = s_ff.wready;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rdata = s_ff.rdata;
  assign s_axi_rresp = s_ff.rresp;
  assign breaker_trip_order = s_ff.trip;
  assign seq_phase_code = s_ff.code;
  assign protection_reinit = s_ff.reinit;
  assign protection_out_of_service = s_ff.running;
  assign energy_counters_freeze = s_ff.running;
  assign sim_volts_phase_neutral = s_ff.running;
  assign sim_quantities = s_ff.sim_out;
  assign sim_freq_mhz = s_ff.freq;
  assign irq = s_ff.irq;

  // Checks on sequencing, aborts, trip gating.
  a_phase_order: assert property ( // RQ1
    @(posedge aclk) disable iff (!aresetn)
    (s_ff.st == fsim_pkg::ST_PRE ##1 s_ff.st != fsim_pkg::ST_PRE) |->
    s_ff.st inside {fsim_pkg::ST_FAULT, fsim_pkg::ST_POST,
                    fsim_pkg::ST_IDLE})
    else $error("pre-fault left to a wrong phase");
  a_reset_code: assert property ( // RQ3
    @(posedge aclk) disable iff (!aresetn)
    s_ff.st inside {fsim_pkg::ST_RST1, fsim_pkg::ST_RST2} |->
    s_ff.code == fsim_pkg::CODE_RESET && s_ff.reinit)
    else $error("reset phase not reported");
  a_over_abort: assert property ( // RQ5
    @(posedge aclk) disable iff (!aresetn)
    (ce && s_ff.running && over) |=>
    s_ff.st == fsim_pkg::ST_IDLE && s_ff.lockout)
    else $error("over current did not abort");
  a_lock_hold: assert property ( // RQ6
    @(posedge aclk) disable iff (!aresetn)
    (s_ff.lockout && s_ff.st == fsim_pkg::ST_IDLE) |=>
    s_ff.st == fsim_pkg::ST_IDLE)
    else $error("start taken during lockout");
  a_block_idle: assert property ( // RQ7
    @(posedge aclk) disable iff (!aresetn)
    (ce && blk) |=> s_ff.st == fsim_pkg::ST_IDLE)
    else $error("simulator ran while blocked");
  a_force_post: assert property ( // RQ8
    @(posedge aclk) disable iff (!aresetn)
    (ce && !over && !blk && !cmd_stop && s_ff.fp_asg &&
     external_jump_to_post_fault &&
     s_ff.st inside {fsim_pkg::ST_PRE, fsim_pkg::ST_FAULT}) |=>
    s_ff.st == fsim_pkg::ST_POST && s_ff.code == fsim_pkg::CODE_POST)
    else $error("force to post-fault missed");
  a_energy_frz: assert property ( // RQ9
    @(posedge aclk) disable iff (!aresetn)
    (s_ff.st != fsim_pkg::ST_IDLE) |->
    energy_counters_freeze && protection_out_of_service)
    else $error("counters not frozen in simulation");
  a_no_trip: assert property ( // RQ12
    @(posedge aclk) disable iff (!aresetn)
    (s_ff.running && !s_ff.with_trip) |-> !breaker_trip_order)
    else $error("trip order leaked in no-trip mode");
  a_with_trip: assert property ( // RQ13
    @(posedge aclk) disable iff (!aresetn)
    (ce && protection_trip_order) ##1 s_ff.with_trip |->
    breaker_trip_order)
    else $error("trip order not passed in with-trip mode");
  a_end_normal: assert property ( // RQ18
    @(posedge aclk) disable iff (!aresetn)
    (ce && !over && !blk && !cmd_stop &&
     s_ff.st == fsim_pkg::ST_RST2 && s_ff.tmr <= 32'h1) |=>
    s_ff.code == fsim_pkg::CODE_NORMAL && !s_ff.running)
    else $error("final reset did not return to normal");

endmodule // fault_simulation_sequencer

// ===== rtl/fsim_pkg.sv
// Purpose: Shared constants and types of the fault simulation sequencer.
// Assumes: 250 MHz system clock, AXI4-Lite with 32-bit data.
// Notes:   Register map, state codes and derived timing counts.
package fsim_pkg;
  // Clock and phase timing.
  localparam int CLK_HZ          = 250_000_000;
  localparam int MS_PER_S        = 1000;
  localparam int RESET_PHASE_MS  = 100;
  localparam int RESET_PHASE_CYC = CLK_HZ / MS_PER_S * RESET_PHASE_MS;
  localparam int QUIET_S         = 5;
  localparam int QUIET_CYC       = CLK_HZ * QUIET_S;
  // Current threshold is one tenth of rated: 10 * i > rated.
  localparam int TENTH_MUL       = 10;
  // Simulated frequency is 0.16 percent above rated.
  localparam int FREQ_NUM        = 16;
  localparam int FREQ_DEN        = 10000;
  // Register byte addresses.
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_DUR_PRE  = 12'h008;
  localparam logic [11:0] ADDR_DUR_FLT  = 12'h00c;
  localparam logic [11:0] ADDR_DUR_POST = 12'h010;
  localparam logic [11:0] ADDR_RATED_I  = 12'h014;
  localparam logic [11:0] ADDR_RATED_F  = 12'h018;
  localparam logic [11:0] ADDR_IRQ_ST   = 12'h01c;
  localparam logic [11:0] ADDR_IRQ_EN   = 12'h020;
  localparam logic [11:0] ADDR_IRQ_CLR  = 12'h024;
  localparam logic [11:0] ADDR_SIM_BASE = 12'h100;
  localparam logic [11:0] ADDR_SIM_LAST = 12'h15c;
  localparam int SIM_CH    = 8;
  localparam int SIM_WORDS = 24;
  // Control register fields.
  localparam int CTRL_START     = 0;
  localparam int CTRL_STOP      = 1;
  localparam int CTRL_WITH_TRIP = 2;
  localparam int CTRL_FP_ASG    = 3;
  localparam int CTRL_LAUNCH_ASG = 4;
  // Interrupt status fields.
  localparam int IRQ_W       = 5;
  localparam int IRQ_STARTED = 0;
  localparam int IRQ_DONE    = 1;
  localparam int IRQ_ABORT   = 2;
  localparam int IRQ_HALT    = 3;
  localparam int IRQ_REFUSED = 4;
  // Reset values.
  localparam logic [31:0] DUR_RST     = 32'h0000_0001;
  localparam logic [15:0] RATED_I_RST = 16'h03e8;
  localparam logic [31:0] RATED_F_RST = 32'h0000_c350;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Phase codes reported to the recorders.
  localparam logic [2:0] CODE_NORMAL = 3'h0;
  localparam logic [2:0] CODE_PRE    = 3'h1;
  localparam logic [2:0] CODE_FAULT  = 3'h2;
  localparam logic [2:0] CODE_POST   = 3'h3;
  localparam logic [2:0] CODE_RESET  = 3'h4;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RST1  = 3'h1,
    ST_PRE   = 3'h3,
    ST_FAULT = 3'h2,
    ST_POST  = 3'h6,
    ST_RST2  = 3'h7
  } seq_state_t;
endpackage

// ===== testbench/prot_side_model.sv
// Purpose: Far side of the sequencer: currents, trip order, breaker state.
// Assumes: The bench changes its commands just after rising aclk edges.
// Notes:   Rated current stays 1000, so a tenth of it is exactly 100.
module prot_side_model (
  input  wire logic        over,
  input  wire logic        trip,
  input  wire logic        brk_closed,
  output logic [15:0]      cur_a,
  output logic [15:0]      cur_b,
  output logic [15:0]      cur_c,
  output logic             trip_out,
  output logic             blk_one
);
  // Sitting on the boundary itself must not abort, one unit more must.
  assign cur_a    = 16'h0064;
  assign cur_b    = over ? 16'h0065 : 16'h0064;
  assign cur_c    = 16'h0000;
  assign trip_out = trip;
  // A closed breaker keeps the sequencer from starting.
  assign blk_one  = brk_closed;
endmodule // prot_side_model

// ===== testbench/test_fault_simulation_sequencer.sv
// Purpose: Self-checking bench of the fault simulation sequencer.
// Assumes: Reset phase shortened to 8 cycles, quiet time to 16.
// Notes:   Phase lengths are measured by a logger at every rising edge.
module test_fault_simulation_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, jmp, launch, blk2;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv, sim_freq_mhz;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] ca, cb, cc;
  logic [255:0] simq;
  logic blk1, trip, trq, over, brk, brk_out, reinit, oos, frz, vpn, irq;
  logic [2:0] seq_phase_code, lastc, codes[$];
  int failures, cmp_count, run, n, lens[$];
  fault_simulation_sequencer #(.RESET_PHASE_CYC(8), .QUIET_CYC(16)) dut (
    .aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phase_current_a(ca),
    .phase_current_b(cb), .phase_current_c(cc), .external_block_one(blk1),
    .external_block_two(blk2), .external_jump_to_post_fault(jmp),
    .external_sim_launch(launch), .protection_trip_order(trq),
    .breaker_trip_order(brk_out), .seq_phase_code, .irq, .sim_freq_mhz,
    .protection_reinit(reinit), .protection_out_of_service(oos),
    .energy_counters_freeze(frz), .sim_volts_phase_neutral(vpn),
    .sim_quantities(simq));
  prot_side_model side (.over, .trip, .brk_closed(brk), .cur_a(ca),
    .cur_b(cb), .cur_c(cc), .trip_out(trq), .blk_one(blk1));
  // Free-running 250 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Each change of phase code stores the code left and how long it held.
  always @(posedge aclk) begin
    if (seq_phase_code !== lastc) begin
      codes.push_back(lastc);
      lens.push_back(run);
      run = 1;
    end else run++;
    lastc = seq_phase_code;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Address and data are offered together; each drops once taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Bounded wait; a code never reached shows up as a mismatch.
  task automatic wait_code(input logic [2:0] c);
    for (n = 0; n < 200 && seq_phase_code !== c; n++) @(posedge aclk);
    chk("phase code", c, seq_phase_code);
  endtask
  // Checks one whole run against pre 3, post 2 and a given fault length.
  task automatic chk_runs(input int fl);
    int ex[5] = '{8, 3, fl, 2, 8}, b;
    @(negedge aclk);
    b = codes.size() - 5;
    for (int i = 0; i < 5; i++) begin
      chk("code order", (i % 4 == 0) ? 4 : i, codes[b + i]);
      chk("phase length", ex[i], lens[b + i]);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog far beyond what the tests need.
  initial begin
    #60000;
    failures++;
    report_and_stop();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, jmp, launch, blk2, trip, over, brk, aresetn} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lastc} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(fsim_pkg::ADDR_DUR_PRE);
    chk("dur reset", fsim_pkg::DUR_RST, rdv);
    rd(12'h200);
    chk("unmapped", fsim_pkg::RESP_SLVERR, rs);
    chk("sim freq", 32'h0000c3a0, sim_freq_mhz);
    $display("test reset values done");
    wr(fsim_pkg::ADDR_DUR_PRE, 3);
    wr(fsim_pkg::ADDR_DUR_FLT, 5);
    wr(fsim_pkg::ADDR_DUR_POST, 2);
    wr(fsim_pkg::ADDR_IRQ_EN, 32'h1f);
    wr(fsim_pkg::ADDR_SIM_BASE + 12'h020, 32'h1234_5678);
    trip <= 1'b1;
    wr(fsim_pkg::ADDR_CTRL, 32'h1);
    chk("reinit", 1, reinit);
    wait_code(fsim_pkg::CODE_FAULT);
    chk("held", 32'hf, {brk_out, frz, oos, vpn} ^ 4'h8);
    chk("sim word", 32'h1234_5678, simq[31:0]);
    wait_code(fsim_pkg::CODE_NORMAL);
    chk_runs(5);
    rd(fsim_pkg::ADDR_IRQ_ST);
    chk("irq status", 3, rdv);
    chk("irq set", 1, irq);
    wr(fsim_pkg::ADDR_IRQ_CLR, 32'h1f);
    chk("irq clear", 0, irq);
    $display("test full run done");
    wr(fsim_pkg::ADDR_CTRL, 32'h5);
    wait_code(fsim_pkg::CODE_FAULT);
    chk("trip out", 1, brk_out);
    wr(fsim_pkg::ADDR_CTRL, 32'h6);
    chk("stopped", 0, seq_phase_code);
    {trip, brk} <= 2'b01;
    wr(fsim_pkg::ADDR_CTRL, 32'h10);
    launch <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("blocked", 0, seq_phase_code);
    rd(fsim_pkg::ADDR_IRQ_ST);
    chk("refused", 32'h18, rdv & 32'h18);
    {launch, brk} <= 2'b00;
    repeat (2) @(posedge aclk);
    launch <= 1'b1;
    wait_code(fsim_pkg::CODE_RESET);
    blk2 <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("block two", 0, seq_phase_code);
    {launch, blk2} <= 2'b00;
    $display("test trip stop block done");
    wr(fsim_pkg::ADDR_CTRL, 32'h1);
    wait_code(fsim_pkg::CODE_PRE);
    over <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("abort", 0, seq_phase_code);
    over <= 1'b0;
    wr(fsim_pkg::ADDR_CTRL, 32'h1);
    repeat (3) @(posedge aclk);
    chk("lockout", 0, seq_phase_code);
    repeat (20) @(posedge aclk);
    wr(fsim_pkg::ADDR_CTRL, 32'h9);
    wait_code(fsim_pkg::CODE_FAULT);
    jmp <= 1'b1;
    wait_code(fsim_pkg::CODE_POST);
    jmp <= 1'b0;
    wait_code(fsim_pkg::CODE_NORMAL);
    chk_runs(2);
    $display("test abort force done");
    report_and_stop();
  end
endmodule // test_fault_simulation_sequencer
